/* dv/port_pin_config_package_code_test.sv */
// Purpose: self-checking bench for the pin config block
// Assumes: default parameters, except pin 15 unbonded under code 4
// Notes: pin tests run with code 4 left behind by the code test
`timescale 1ns/1ps
`default_nettype none
module port_pin_config_package_code_test;
  import ppc_pkg::*;
  localparam logic [31:0] PKG = {18'h0, PPC_PKG_CODE_ADDR};
  localparam logic [127:0] BOND = {8'hEF, {15{8'hFF}}};
  localparam logic [31:0] CTL = {18'h0, PPC_CTRL_ADDR};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF, port_dir_out = '0, port_dout = '0, port_pin_o, port_pin_oe;
  logic pready, pslverr, special_mode = 0, flash_code_valid = 0, periodic_int_clock_out = 0;
  logic [2:0] flash_code = 3'h0, package_code_field;
  logic [15:0] per_pin_input_enable = '0, pin_input_buffer_enable;
  logic aux_clk_default_pin_o, alternate_clock_pin_o;
  int bad_count = 0, tests_run = 0, cycles = 0;
  ppc_top #(.BOND_MAP(BOND)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata,
    .pready, .pslverr, .special_mode, .flash_code_valid, .flash_code, .per_pin_input_enable,
    .port_dir_out, .port_dout, .port_pin_o, .port_pin_oe, .pin_input_buffer_enable,
    .periodic_int_clock_out, .aux_clk_default_pin_o, .alternate_clock_pin_o,
    .package_code_field);
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
  endtask
  task automatic t_code;
    flash_code <= 3'h5;
    flash_code_valid <= 1'b1;
    @(posedge pclk);
    flash_code_valid <= 1'b0;
    periodic_int_clock_out <= 1'b1;
    rdchk(PKG, 32'h05);
    apb(1'b1, PKG, 32'h83);
    rdchk(PKG, 32'h83);
    chk(32'({alternate_clock_pin_o, aux_clk_default_pin_o}), 32'h2);
    apb(1'b1, PKG, 32'h02);
    rdchk(PKG, 32'h03);
    chk(32'({alternate_clock_pin_o, aux_clk_default_pin_o}), 32'h1);
    special_mode <= 1'b1;
    apb(1'b1, PKG, 32'h06);
    rdchk(PKG, 32'h07);
    apb(1'b1, PKG, 32'h04);
    rdchk(PKG, 32'h04);
    apb(1'b0, 32'h0, '0);
    chk(32'(err), 32'h1);
    $display("code test done");
  endtask
  task automatic t_pins;
    logic [15:0] ctl [5] = '{16'h0100, 16'h0900, 16'h0D00, 16'h0300, 16'h0A00};
    logic [15:0] exp [5] = '{16'h00F0, 16'h7FFF, 16'h00F0, 16'h7FFF, 16'h0000};
    per_pin_input_enable <= 16'h00F0;
    port_dir_out <= 4'hF;
    port_dout <= 4'h5;
    foreach (ctl[i]) begin
      apb(1'b1, CTL, {16'h0, ctl[i]});
      chk(32'(pin_input_buffer_enable), 32'(exp[i]));
    end
    apb(1'b1, CTL, 32'hF);
    chk(32'({port_pin_oe, port_pin_o}), 32'hA0);
    apb(1'b1, CTL, 32'h0);
    chk(32'({port_pin_oe, port_pin_o}), 32'hF5);
    port_dir_out <= 4'h0;
    @(posedge pclk);
    chk(32'(port_pin_oe), 32'h0);
    $display("pin test done");
  endtask
  task automatic give_verdict;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(PKG, 32'(PPC_PKG_CODE_RESET));
    t_code();
    t_pins();
    give_verdict();
  end
endmodule
`default_nettype wire

/* dv/ppc_checker.sv */
// Purpose: port checks for the pin config block
// Assumes: pready always high, lock state is internal
// Notes: code write checks are made only in special mode
`timescale 1ns/1ps
`default_nettype none
module ppc_checker #(
  parameter int OD_PINS = 4,
  parameter logic [2:0] MAX_CODE = 3'h5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic special_mode,
  input wire logic flash_code_valid,
  input wire logic [OD_PINS-1:0] port_dir_out,
  input wire logic [OD_PINS-1:0] port_dout,
  input wire logic [OD_PINS-1:0] port_pin_o,
  input wire logic [OD_PINS-1:0] port_pin_oe,
  input wire logic periodic_int_clock_out,
  input wire logic alternate_clock_pin_o,
  input wire logic [2:0] package_code_field
);
  import ppc_pkg::*;
  logic acc;
  logic wr;
  assign acc = psel & penable & (paddr == {18'h0, PPC_PKG_CODE_ADDR});
  assign wr = acc & pwrite & pstrb[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_drv; (port_pin_o & port_pin_oe) == (port_dout & port_pin_oe); endproperty
  a_drv: assert property (p_drv) else $error("driven level differs");
  property p_low; (port_dir_out & ~port_dout & ~port_pin_oe) == '0; endproperty
  a_low: assert property (p_low) else $error("zero not driven");
  property p_in; (port_pin_oe & ~port_dir_out) == '0; endproperty
  a_in: assert property (p_in) else $error("input pin driven");
  property p_rt; wr |=> alternate_clock_pin_o == ($past(pwdata[7]) & periodic_int_clock_out);
  endproperty
  a_rt: assert property (p_rt) else $error("clock route wrong");
  property p_rd; acc & !pwrite |-> prdata[7:0] == {prdata[7], 4'h0, package_code_field};
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_clamp; wr & special_mode & (pwdata[2:0] > MAX_CODE) |=> package_code_field == 3'h7;
  endproperty
  a_clamp: assert property (p_clamp) else $error("code not clamped");
  property p_keep; wr & special_mode & (pwdata[2:0] <= MAX_CODE) |=>
    package_code_field == $past(pwdata[2:0]); endproperty
  a_keep: assert property (p_keep) else $error("code altered");
  property p_hold; !wr && !flash_code_valid |=> $stable(package_code_field); endproperty
  a_hold: assert property (p_hold) else $error("code moved");
endmodule
bind ppc_top ppc_checker #(.OD_PINS(OD_PINS), .MAX_CODE(MAX_CODE)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .special_mode, .flash_code_valid,
  .port_dir_out, .port_dout, .port_pin_o, .port_pin_oe, .periodic_int_clock_out,
  .alternate_clock_pin_o, .package_code_field);
`default_nettype wire

/* rtl/ppc_od_pin.sv */
// Purpose: one output driver with open-drain or push-pull choice
// Assumes: output enable high while the pin is driven
// Notes: a pin used as input ignores the open-drain choice
`timescale 1ns/1ps
`default_nettype none
module ppc_od_pin (
  input wire logic open_drain,
  input wire logic dir_out,
  input wire logic dout,
  output logic pin_o,
  output logic pin_oe
);
  always_comb begin
    pin_o = dout;
    if (!dir_out) begin
      pin_oe = 1'b0;
    end else if (open_drain) begin
      pin_o = 1'b0;
      pin_oe = ~dout;
    end else begin
      pin_oe = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* rtl/ppc_pkg.sv */
// Purpose: constants for the port pin configuration and package code block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: package code index 0x257 is not a multiple of four, so byte address is 4x index
package ppc_pkg;
  localparam logic [11:0] PPC_PKG_CODE_INDEX = 12'h257;
  localparam logic [13:0] PPC_PKG_CODE_ADDR = {PPC_PKG_CODE_INDEX, 2'b00};
  localparam logic [13:0] PPC_CTRL_ADDR = 14'h0A00;
  localparam logic [13:0] PPC_STAT_ADDR = 14'h0A04;
  localparam int PPC_ROUTE_BIT = 7;
  localparam int PPC_CODE_LSB = 0;
  localparam int PPC_CODE_W = 3;
  localparam logic [2:0] PPC_CODE_MAX = 3'h7;
  localparam logic [7:0] PPC_PKG_CODE_RESET = 8'h00;
  localparam int PPC_CTRL_OD_LSB = 0;
  localparam int PPC_CTRL_OD_W = 4;
  localparam int PPC_CTRL_CMP_BIT = 8;
  localparam int PPC_CTRL_REROUTE_BIT = 9;
  localparam int PPC_CTRL_TRIGSEL_BIT = 10;
  localparam int PPC_CTRL_TRIGEN_BIT = 11;
  localparam int PPC_STAT_LOCK_BIT = 3;
endpackage

/* rtl/ppc_top.sv */
// Purpose: analog port input buffer gating, open-drain port, package code register
// Assumes: flash supplies the factory code with flash_code_valid pulse after reset
// Notes: written codes above max_code are folded to the largest option
// What this block does
// - input buffer on iff pin bonded for the package code, comparator enable and (pin enable or trigger or reroute)
// - open-drain pin drives zero low and leaves one undriven
// - mode bit one is open-drain, zero push-pull, no effect on inputs
// - package register at index 0x257, always readable, bits 6..3 zero, flash preload
// - route bit writable anytime; code anytime in special mode, once in normal after reset or a special-mode write
// - route bit one moves the aux clock output to the alternate pin
// - reserved or too large written codes are stored as 0b111
// - smaller package codes are stored unchanged
// - unbonded pins lose input buffers per package code
`timescale 1ns/1ps
`default_nettype none
module ppc_top #(
  parameter int AD_PINS = 16,
  parameter int OD_PINS = 4,
  parameter logic [2:0] MAX_CODE = 3'h5,
  parameter logic [7:0] RESERVED_CODES = 8'h00,
  parameter logic [AD_PINS*8-1:0] BOND_MAP = {(AD_PINS*8){1'b1}}
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic flash_code_valid,
  input wire logic [2:0] flash_code,
  input wire logic [AD_PINS-1:0] per_pin_input_enable,
  input wire logic [OD_PINS-1:0] port_dir_out,
  input wire logic [OD_PINS-1:0] port_dout,
  output logic [OD_PINS-1:0] port_pin_o,
  output logic [OD_PINS-1:0] port_pin_oe,
  output logic [AD_PINS-1:0] pin_input_buffer_enable,
  input wire logic periodic_int_clock_out,
  output logic aux_clk_default_pin_o,
  output logic alternate_clock_pin_o,
  output logic [2:0] package_code_field
);
  import ppc_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // wider pin counts would overrun the control word and read layout
  if (AD_PINS < 1 || AD_PINS > 32) begin : g_bad_ad
    $error("ppc_top: unsupported analog pin count");
  end
  if (OD_PINS < 1 || OD_PINS > 8) begin : g_bad_od
    $error("ppc_top: unsupported open-drain pin count");
  end
  if (RESERVED_CODES[PPC_CODE_MAX]) begin : g_bad_res
    $error("ppc_top: the clamp target code cannot be reserved");
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic [13:0] addr;
  logic wr_en;
  logic hit_pkg, hit_ctrl, hit_stat;
  assign addr = paddr[13:0];
  assign hit_pkg = (addr == PPC_PKG_CODE_ADDR) && (paddr[31:14] == 18'h00000);
  assign hit_ctrl = (addr == PPC_CTRL_ADDR) && (paddr[31:14] == 18'h00000);
  assign hit_stat = (addr == PPC_STAT_ADDR) && (paddr[31:14] == 18'h00000);
  assign wr_en = psel && penable && pwrite;
  // zero wait states: every register answers in its access cycle
  assign pready = 1'b1;
  // unmapped accesses get an error so software bugs surface
  assign pslverr = psel && penable && !(hit_pkg || hit_ctrl || hit_stat);

  // ----------------------------------------
  // package code register
  // ----------------------------------------
  logic route_q, route_d;
  logic [2:0] code_q, code_d;
  logic locked_q, locked_d;
  logic [2:0] wcode;

  function automatic logic [2:0] clamp_code(input logic [2:0] c);
    if (RESERVED_CODES[c] || c > MAX_CODE) begin
      clamp_code = PPC_CODE_MAX;
    end else begin
      clamp_code = c;
    end
  endfunction

  always_comb begin
    route_d = route_q;
    code_d = code_q;
    locked_d = locked_q;
    wcode = pwdata[PPC_CODE_LSB +: PPC_CODE_W];
    // factory code is trusted: neither clamped nor locking
    if (flash_code_valid) begin
      code_d = flash_code;
    end
    if (wr_en && hit_pkg && pstrb[0]) begin
      route_d = pwdata[PPC_ROUTE_BIT];
      if (special_mode || !locked_q) begin
        code_d = clamp_code(wcode);
        locked_d = !special_mode;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= PPC_PKG_CODE_RESET[PPC_ROUTE_BIT];
      code_q <= PPC_PKG_CODE_RESET[PPC_CODE_W-1:0];
      locked_q <= 1'b0;
    end else begin
      route_q <= route_d;
      code_q <= code_d;
      locked_q <= locked_d;
    end
  end
  assign package_code_field = code_q;

  // ----------------------------------------
  // control register for port and converter bits
  // ----------------------------------------
  logic [OD_PINS-1:0] od_q, od_d;
  logic cmp_en_q, cmp_en_d, reroute_q, reroute_d, tsel_q, tsel_d, ten_q, ten_d;

  always_comb begin
    od_d = od_q;
    cmp_en_d = cmp_en_q;
    reroute_d = reroute_q;
    tsel_d = tsel_q;
    ten_d = ten_q;
    if (wr_en && hit_ctrl) begin
      if (pstrb[0]) begin
        od_d = pwdata[PPC_CTRL_OD_LSB +: OD_PINS];
      end
      if (pstrb[1]) begin
        cmp_en_d = pwdata[PPC_CTRL_CMP_BIT];
        reroute_d = pwdata[PPC_CTRL_REROUTE_BIT];
        tsel_d = pwdata[PPC_CTRL_TRIGSEL_BIT];
        ten_d = pwdata[PPC_CTRL_TRIGEN_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_q <= '0;
      cmp_en_q <= 1'b0;
      reroute_q <= 1'b0;
      tsel_q <= 1'b0;
      ten_q <= 1'b0;
    end else begin
      od_q <= od_d;
      cmp_en_q <= cmp_en_d;
      reroute_q <= reroute_d;
      tsel_q <= tsel_d;
      ten_q <= ten_d;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    // unused bits read as zero
    prdata = 32'h00000000;
    if (hit_pkg) begin
      prdata[PPC_ROUTE_BIT] = route_q;
      prdata[PPC_CODE_LSB +: PPC_CODE_W] = code_q;
    end else if (hit_ctrl) begin
      prdata[PPC_CTRL_OD_LSB +: OD_PINS] = od_q;
      prdata[PPC_CTRL_CMP_BIT] = cmp_en_q;
      prdata[PPC_CTRL_REROUTE_BIT] = reroute_q;
      prdata[PPC_CTRL_TRIGSEL_BIT] = tsel_q;
      prdata[PPC_CTRL_TRIGEN_BIT] = ten_q;
    end else if (hit_stat) begin
      prdata[PPC_STAT_LOCK_BIT] = locked_q;
      prdata[PPC_CODE_LSB +: PPC_CODE_W] = code_q;
    end
  end

  // ----------------------------------------
  // input buffers and clock routing
  // ----------------------------------------
  logic [7:0] bond_sel;
  always_comb begin
    bond_sel = '0;
    for (int i = 0; i < AD_PINS; i++) begin
      bond_sel = BOND_MAP[i*8 +: 8];
      // unbonded pins stay off to avoid shoot-through current
      pin_input_buffer_enable[i] = bond_sel[code_q] && cmp_en_q &&
        (per_pin_input_enable[i] || (!tsel_q && ten_q) || reroute_q);
    end
  end

  assign alternate_clock_pin_o = route_q && periodic_int_clock_out;
  assign aux_clk_default_pin_o = !route_q && periodic_int_clock_out;

  // ----------------------------------------
  // port drivers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < OD_PINS; g++) begin : g_od
      ppc_od_pin u_pin (
        .open_drain(od_q[g]),
        .dir_out(port_dir_out[g]),
        .dout(port_dout[g]),
        .pin_o(port_pin_o[g]),
        .pin_oe(port_pin_oe[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire
